//--- include/i2c_port_map.svh
// Constants of the two-wire serial bus port: depths, timing, bit positions
`ifndef I2C_PORT_MAP_SVH
`define I2C_PORT_MAP_SVH

// ==========================================================
// Buffering
`define FIFO_DEPTH    32
`define CMD_W         10
`define RX_W          9

// ==========================================================
// Line timing, pad clock domain
`define PAD_CLK_NS    12
`define STD_HALF_NS   5000
`define FAST_HALF_NS  1250
`define STD_HALF_CYC  9'((`STD_HALF_NS + `PAD_CLK_NS - 1) / `PAD_CLK_NS)
`define FAST_HALF_CYC 9'((`FAST_HALF_NS + `PAD_CLK_NS - 1) / `PAD_CLK_NS)

// ==========================================================
// Byte framing and addressing
`define BIT_PRE       4'hf
`define BIT_LAST      4'h7
`define BIT_ACK       4'h8
`define BIT_ZERO      4'h0
`define GC_BIT        0
`define GC_ADDR       7'h00

// ==========================================================
// Event toggles handed to the system clock
`define EV_W          3
`define EV_MATCH      0
`define EV_LOST       1
`define EV_NACK       2

`endif

//--- include/i2c_port_pkg.sv
// Types of the two-wire serial bus port
package i2c_port_pkg;

  typedef enum logic [1:0] {
    CMD_START,
    CMD_WRITE,
    CMD_READ,
    CMD_STOP
  } cmd_kind_t;

  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_LOW,
    M_HIGH,
    M_RS1,
    M_RS2,
    M_STOP1,
    M_STOP2
  } mst_state_t;

endpackage

//--- src/two_wire_serial_bus_port.sv
// Two-wire serial bus port: async word FIFO and the bus engine top
`include "i2c_port_map.svh"

// ==========================================================
// Dual-clock FIFO with gray pointers
module async_word_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         wclk,
  input  wire logic         wrst_n,
  input  wire logic         w_valid,
  output logic              w_ready,
  input  wire logic [W-1:0] w_data,
  input  wire logic         rclk,
  input  wire logic         rrst_n,
  output logic              r_valid,
  input  wire logic         r_ready,
  output logic [W-1:0]      r_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_q, wbin_d, wgray_q, wgray_d, rq1_q, rq2_q;
  logic [AW:0]  rbin_q, rbin_d, rgray_q, rgray_d, wq1_q, wq2_q;
  logic         wfull_d, rempty_d, w_ready_q, r_valid_q;
  logic [W-1:0] r_data_q;

  assign w_ready = w_ready_q;
  assign r_valid = r_valid_q;
  assign r_data  = r_data_q;

  always_comb begin
    wbin_d   = wbin_q + (AW+1)'(w_valid & w_ready_q);
    wgray_d  = (wbin_d >> 1) ^ wbin_d;
    wfull_d  = wgray_d == {~rq2_q[AW:AW-1], rq2_q[AW-2:0]};
    rbin_d   = rbin_q + (AW+1)'(r_valid_q & r_ready);
    rgray_d  = (rbin_d >> 1) ^ rbin_d;
    rempty_d = rgray_d == wq2_q;
  end

  // Storage is not reset; pointers guard every read
  always_ff @(posedge wclk) begin
    if (w_valid && w_ready_q) begin
      mem[wbin_q[AW-1:0]] <= w_data;
    end
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_q    <= '0;
      wgray_q   <= '0;
      rq1_q     <= '0;
      rq2_q     <= '0;
      w_ready_q <= 1'b0;
    end else begin
      wbin_q    <= wbin_d;
      wgray_q   <= wgray_d;
      rq1_q     <= rgray_q;
      rq2_q     <= rq1_q;
      w_ready_q <= ~wfull_d;
    end
  end

  // Read data is registered from the next pointer, so it stays a flop
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_q    <= '0;
      rgray_q   <= '0;
      wq1_q     <= '0;
      wq2_q     <= '0;
      r_valid_q <= 1'b0;
      r_data_q  <= '0;
    end else begin
      rbin_q    <= rbin_d;
      rgray_q   <= rgray_d;
      wq1_q     <= wgray_q;
      wq2_q     <= wq1_q;
      r_valid_q <= ~rempty_d;
      r_data_q  <= mem[rbin_d[AW-1:0]];
    end
  end
endmodule

// ==========================================================
// Bus port top
module two_wire_serial_bus_port
  import i2c_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       pad_clk,
  input  wire logic       port_enable_bit,
  input  wire logic       fast_mode,
  input  wire logic [7:0] own_address_register,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd_kind,
  input  wire logic [7:0] cmd_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            rx_is_addr,
  output logic [7:0]      rx_data,
  output logic            addr_match_irq,
  output logic            arb_lost,
  output logic            nack_seen,
  output logic            bus_busy,
  input  wire logic       serial_clock_line_i,
  output logic            serial_clock_line_o,
  output logic            serial_clock_line_oe_n,
  input  wire logic       serial_data_line_i,
  output logic            serial_data_line_o,
  output logic            serial_data_line_oe_n
);
  // ==========================================================
  // Reset release in both domains
  logic rst_s1_q, rst_n_q, prst_s1_q, prst_n_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  always_ff @(posedge pad_clk or negedge arst_n) begin
    if (!arst_n) begin
      prst_s1_q <= 1'b0;
      prst_n_q  <= 1'b0;
    end else begin
      prst_s1_q <= 1'b1;
      prst_n_q  <= prst_s1_q;
    end
  end

  // ==========================================================
  // Buffers crossing between system and pad clocks
  logic [`CMD_W-1:0] cmd_word;
  logic [`RX_W-1:0]  rx_word;
  logic              cmd_have, cmd_pop, rx_wready, rx_push;
  logic              rx_is_addr_w;
  cmd_kind_t         head_kind;

  async_word_fifo #(.W(`CMD_W), .DEPTH(`FIFO_DEPTH)) u_cmd_fifo (
    .wclk    (clk),
    .wrst_n  (rst_n_q),
    .w_valid (cmd_valid),
    .w_ready (cmd_ready),
    .w_data  ({cmd_kind, cmd_data}),
    .rclk    (pad_clk),
    .rrst_n  (prst_n_q),
    .r_valid (cmd_have),
    .r_ready (cmd_pop),
    .r_data  (cmd_word)
  );

  async_word_fifo #(.W(`RX_W), .DEPTH(`FIFO_DEPTH)) u_rx_fifo (
    .wclk    (pad_clk),
    .wrst_n  (prst_n_q),
    .w_valid (rx_push),
    .w_ready (rx_wready),
    .w_data  (rx_word),
    .rclk    (clk),
    .rrst_n  (rst_n_q),
    .r_valid (rx_valid),
    .r_ready (rx_ready),
    .r_data  ({rx_is_addr_w, rx_data})
  );

  assign rx_is_addr = rx_is_addr_w;
  assign head_kind  = cmd_kind_t'(cmd_word[9:8]);

  // ==========================================================
  // Pad side synchronisers; stage one feeds stage two only
  logic       scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q;
  logic [9:0] cfg_s1_q, cfg_s2_q;
  logic       en, fast, gc_en, rise, fall, start_det, stop_det;
  logic [6:0] own;

  always_ff @(posedge pad_clk or negedge prst_n_q) begin
    if (!prst_n_q) begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= {serial_clock_line_i, scl_s1_q,
                                        scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_p_q} <= {serial_data_line_i, sda_s1_q,
                                        sda_s2_q};
      cfg_s1_q <= {port_enable_bit, fast_mode, own_address_register};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  assign en        = cfg_s2_q[9];
  assign fast      = cfg_s2_q[8];
  assign own       = cfg_s2_q[7:1];
  assign gc_en     = cfg_s2_q[`GC_BIT];
  assign rise      = scl_s2_q & ~scl_p_q;
  assign fall      = ~scl_s2_q & scl_p_q;
  assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  // ==========================================================
  // Bus engine, pad clock
  mst_state_t       st_q, st_d;
  logic [8:0]       tim_q, tim_d, half;
  logic [3:0]       bit_q, bit_d;
  logic [7:0]       shift_q, shift_d;
  logic [`EV_W-1:0] ev_q, ev_d;
  logic busy_q, busy_d, active_q, active_d, mst_q, mst_d, xmit_q, xmit_d;
  logic addr_ph_q, addr_ph_d, ackv_q, ackv_d, nacked_q, nacked_d;
  logic hold_q, hold_d, push_q, push_d, push_addr_q, push_addr_d;
  logic gen_low_q, gen_low_d, sda_low_q, sda_low_d;
  logic scl_oe_n_q, sda_oe_n_q, need_cmd, match;

  assign rx_word = {push_addr_q, shift_q};

  always_comb begin
    st_d        = st_q;
    tim_d       = (tim_q != '0) ? tim_q - 9'h1 : tim_q;
    bit_d       = bit_q;
    shift_d     = shift_q;
    ev_d        = ev_q;
    busy_d      = busy_q;
    active_d    = active_q;
    mst_d       = mst_q;
    xmit_d      = xmit_q;
    addr_ph_d   = addr_ph_q;
    ackv_d      = ackv_q;
    nacked_d    = nacked_q;
    hold_d      = hold_q;
    push_d      = push_q;
    push_addr_d = push_addr_q;
    gen_low_d   = gen_low_q;
    sda_low_d   = sda_low_q;
    cmd_pop     = 1'b0;
    rx_push     = 1'b0;
    need_cmd    = mst_q | xmit_q;
    half        = fast ? `FAST_HALF_CYC : `STD_HALF_CYC;
    match       = en & ((shift_q[7:1] == own) |
                        (gc_en & (shift_q[7:1] == `GC_ADDR)));
    if (start_det) busy_d = 1'b1;
    if (stop_det) busy_d = 1'b0;

    unique case (st_q)
      M_IDLE: begin
        // Claim only a free bus: both lines high and no transfer open
        if (en && !busy_q && scl_s2_q && sda_s2_q && cmd_have &&
            head_kind == CMD_START) begin
          cmd_pop   = 1'b1;
          mst_d     = 1'b1;
          active_d  = 1'b1;
          addr_ph_d = 1'b1;
          xmit_d    = 1'b1;
          shift_d   = cmd_word[7:0];
          bit_d     = `BIT_PRE;
          sda_low_d = 1'b1;
          tim_d     = half;
          st_d      = M_START;
        end
      end
      M_START: if (tim_q == '0) begin
        gen_low_d = 1'b1;
        tim_d     = half;
        st_d      = M_LOW;
      end
      M_LOW: if (tim_q == '0 && !hold_q) begin
        gen_low_d = 1'b0;
        tim_d     = half;
        st_d      = M_HIGH;
      end
      M_HIGH: begin
        // High time counts only once the line is really high
        if (fall) begin
          gen_low_d = 1'b1;
          tim_d     = half;
          st_d      = M_LOW;
        end else if (!scl_s2_q) begin
          tim_d = half;
        end else if (tim_q == '0) begin
          gen_low_d = 1'b1;
          tim_d     = half;
          st_d      = M_LOW;
        end
      end
      M_RS1: if (tim_q == '0) begin
        gen_low_d = 1'b0;
        tim_d     = half;
        st_d      = M_RS2;
      end
      M_RS2: begin
        if (!scl_s2_q) begin
          tim_d = half;
        end else if (tim_q == '0) begin
          sda_low_d = 1'b1;
          tim_d     = half;
          st_d      = M_START;
        end
      end
      M_STOP1: if (tim_q == '0) begin
        gen_low_d = 1'b0;
        tim_d     = half;
        st_d      = M_STOP2;
      end
      M_STOP2: begin
        if (!scl_s2_q) begin
          tim_d = half;
        end else if (tim_q == '0) begin
          sda_low_d = 1'b0;
          mst_d     = 1'b0;
          st_d      = M_IDLE;
        end
      end
    endcase

    // Sample on the rising clock edge
    if (active_q && rise && bit_q != `BIT_PRE) begin
      if (bit_q != `BIT_ACK) begin
        shift_d = {shift_q[6:0], sda_s2_q};
        // Released a one but the line reads zero: another master won
        if (mst_q && xmit_q && !sda_low_q && !sda_s2_q) begin
          ev_d[`EV_LOST] = ~ev_q[`EV_LOST];
          mst_d     = 1'b0;
          xmit_d    = 1'b0;
          gen_low_d = 1'b0;
          st_d      = M_IDLE;
          active_d  = addr_ph_q;
        end
      end else begin
        nacked_d = xmit_q & sda_s2_q;
      end
    end

    // Change the data line after the falling clock edge
    if (active_q && fall) begin
      if (bit_q == `BIT_PRE || bit_q < `BIT_LAST) begin
        bit_d     = (bit_q == `BIT_PRE) ? `BIT_ZERO : bit_q + 4'h1;
        sda_low_d = xmit_q & ~shift_q[7];
      end else if (bit_q == `BIT_LAST) begin
        bit_d = `BIT_ACK;
        if (addr_ph_q && !mst_q) begin
          sda_low_d = match;
          active_d  = match;
        end else begin
          sda_low_d = ~xmit_q & ~ackv_q;
        end
      end else begin
        bit_d     = `BIT_ZERO;
        sda_low_d = 1'b0;
        hold_d    = 1'b1;
        push_d    = ~xmit_q;
        push_addr_d = addr_ph_q;
        if (addr_ph_q) begin
          addr_ph_d = 1'b0;
          if (!mst_q) begin
            xmit_d = shift_q[0];
            ackv_d = 1'b0;
            ev_d[`EV_MATCH] = ~ev_q[`EV_MATCH];
          end
        end
        if (xmit_q && nacked_q) begin
          if (mst_q) begin
            ev_d[`EV_NACK] = ~ev_q[`EV_NACK];
          end else begin
            active_d = 1'b0;
            hold_d   = 1'b0;
          end
        end
      end
    end

    // Hold the clock low until buffers allow the next byte
    if (hold_q && (!push_q || rx_wready) &&
        (!need_cmd || cmd_have)) begin
      rx_push = push_q;
      push_d  = 1'b0;
      hold_d  = 1'b0;
      if (need_cmd) begin
        cmd_pop = 1'b1;
        if (!mst_q || head_kind == CMD_WRITE) begin
          shift_d   = cmd_word[7:0];
          xmit_d    = 1'b1;
          sda_low_d = ~cmd_word[7];
        end else if (head_kind == CMD_READ) begin
          xmit_d = 1'b0;
          ackv_d = cmd_word[0];
        end else if (head_kind == CMD_START) begin
          shift_d   = cmd_word[7:0];
          xmit_d    = 1'b1;
          addr_ph_d = 1'b1;
          bit_d     = `BIT_PRE;
          tim_d     = half;
          st_d      = M_RS1;
        end else begin
          sda_low_d = 1'b1;
          tim_d     = half;
          st_d      = M_STOP1;
        end
      end
    end

    if (start_det && !mst_q) begin
      active_d  = en;
      addr_ph_d = 1'b1;
      xmit_d    = 1'b0;
      bit_d     = `BIT_PRE;
      hold_d    = 1'b0;
      push_d    = 1'b0;
      sda_low_d = 1'b0;
    end
    // Disabled port releases both lines unless it is bus master, as parked latches expect
    if ((stop_det && !mst_q) || (!en && !mst_q)) begin
      active_d  = 1'b0;
      hold_d    = 1'b0;
      push_d    = 1'b0;
      sda_low_d = 1'b0;
    end
  end

  always_ff @(posedge pad_clk or negedge prst_n_q) begin
    if (!prst_n_q) begin
      st_q        <= M_IDLE;
      tim_q       <= '0;
      bit_q       <= `BIT_PRE;
      shift_q     <= '0;
      ev_q        <= '0;
      busy_q      <= 1'b0;
      active_q    <= 1'b0;
      mst_q       <= 1'b0;
      xmit_q      <= 1'b0;
      addr_ph_q   <= 1'b0;
      ackv_q      <= 1'b0;
      nacked_q    <= 1'b0;
      hold_q      <= 1'b0;
      push_q      <= 1'b0;
      push_addr_q <= 1'b0;
      gen_low_q   <= 1'b0;
      sda_low_q   <= 1'b0;
      scl_oe_n_q  <= 1'b1;
      sda_oe_n_q  <= 1'b1;
    end else begin
      st_q        <= st_d;
      tim_q       <= tim_d;
      bit_q       <= bit_d;
      shift_q     <= shift_d;
      ev_q        <= ev_d;
      busy_q      <= busy_d;
      active_q    <= active_d;
      mst_q       <= mst_d;
      xmit_q      <= xmit_d;
      addr_ph_q   <= addr_ph_d;
      ackv_q      <= ackv_d;
      nacked_q    <= nacked_d;
      hold_q      <= hold_d;
      push_q      <= push_d;
      push_addr_q <= push_addr_d;
      gen_low_q   <= gen_low_d;
      sda_low_q   <= sda_low_d;
      scl_oe_n_q  <= ~(gen_low_d | hold_d);
      sda_oe_n_q  <= ~sda_low_d;
    end
  end

  // Open drain: the pads only ever drive zero
  assign serial_clock_line_o    = 1'b0;
  assign serial_data_line_o     = 1'b0;
  assign serial_clock_line_oe_n = scl_oe_n_q;
  assign serial_data_line_oe_n  = sda_oe_n_q;

  // ==========================================================
  // Events and bus state back to the system clock
  logic [`EV_W-1:0] ev_s1_q, ev_s2_q, ev_s3_q, ev_pls_q;
  logic             busy_s1_q, busy_s2_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ev_s1_q   <= '0;
      ev_s2_q   <= '0;
      ev_s3_q   <= '0;
      ev_pls_q  <= '0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      ev_s1_q   <= ev_q;
      ev_s2_q   <= ev_s1_q;
      ev_s3_q   <= ev_s2_q;
      ev_pls_q  <= ev_s2_q ^ ev_s3_q;
      busy_s1_q <= busy_q;
      busy_s2_q <= busy_s1_q;
    end
  end

  assign addr_match_irq = ev_pls_q[`EV_MATCH];
  assign arb_lost       = ev_pls_q[`EV_LOST];
  assign nack_seen      = ev_pls_q[`EV_NACK];
  assign bus_busy       = busy_s2_q;
endmodule

//--- verification/two_wire_serial_bus_port_properties.sv
// Concurrent checks on the bus port pins and status ports
module two_wire_serial_bus_port_properties (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       pad_clk,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       addr_match_irq,
  input wire logic       nack_seen,
  input wire logic       bus_busy,
  input wire logic       serial_clock_line_i,
  input wire logic       serial_clock_line_o,
  input wire logic       serial_clock_line_oe_n,
  input wire logic       serial_data_line_i,
  input wire logic       serial_data_line_o
);
  wire scl = serial_clock_line_i;
  wire sda = serial_data_line_i;

  // ==========================================================
  // Pins
  a_scl_low_only: assert property (
    @(posedge pad_clk) disable iff (!arst_n) serial_clock_line_o == 1'b0)
    else $error("clock pin drives high");
  a_sda_low_only: assert property (
    @(posedge pad_clk) disable iff (!arst_n) !serial_data_line_o)
    else $error("data pin drives high");
  // Lines move slowly against clk, so clk sampling sees every edge
  a_start_busy: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(sda) && scl && $past(scl) |-> ##[1:8] bus_busy)
    else $error("START not flagged busy");
  a_stop_idle: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(sda) && scl && $past(scl) |-> ##[1:8] !bus_busy)
    else $error("STOP not flagged free");
  a_clock_when_busy: assert property (
    @(posedge clk) disable iff (!arst_n)
    !serial_clock_line_oe_n |-> bus_busy)
    else $error("clock pulled outside a transfer");

  // ==========================================================
  // Status ports
  a_match_pulse: assert property (
    @(posedge clk) disable iff (!arst_n) addr_match_irq |=> !addr_match_irq)
    else $error("match pulse too long");
  a_irq_in_frame: assert property (
    @(posedge clk) disable iff (!arst_n) addr_match_irq |-> bus_busy)
    else $error("match outside a transfer");
  a_nack_pulse: assert property (
    @(posedge clk) disable iff (!arst_n) $rose(nack_seen) |=> $fell(nack_seen))
    else $error("nack pulse too long");
  a_rx_holds: assert property (
    @(posedge clk) disable iff (!arst_n)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx word lost before pop");

  c_start: cover property (@(posedge clk) $rose(bus_busy));
  c_match: cover property (@(posedge clk) addr_match_irq);
  c_nack:  cover property (@(posedge clk) nack_seen);
  c_pop:   cover property (@(posedge clk) rx_valid && rx_ready);
endmodule

//--- verification/bus_slave_model.sv
// Behavioural slave device on the two-wire bus, optional clock stretch
module bus_slave_model #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] RD   = 8'ha5
) (
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  stretch,
  output logic       scl_pull,
  output logic       sda_pull,
  output logic [7:0] last_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    last_wr  = 8'h00;
  end

  // ==========================================================
  // Byte engine
  task automatic rx_byte();
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl) b[i] = sda;
    end
  endtask

  task automatic give_ack(input logic a);
    @(negedge scl) sda_pull = a;
    @(negedge scl) sda_pull = 1'b0;
    if (stretch) begin
      scl_pull = 1'b1;
      #20000 scl_pull = 1'b0;
    end
  endtask

  task automatic frame();
    rx_byte();
    give_ack(b[7:1] == ADDR);
    if (b[7:1] != ADDR) wait (0);
    else if (!b[0]) forever begin
      rx_byte();
      last_wr = b;
      give_ack(1'b1);
    end
    else forever begin
      for (int i = 7; i >= 0; i--) begin
        sda_pull = !RD[i];
        @(negedge scl);
      end
      sda_pull = 1'b0;
      @(posedge scl);
      if (sda) wait (0);
      @(negedge scl);
    end
  endtask

  // ==========================================================
  // START launches a frame, STOP cuts it off
  always @(negedge sda) begin
    if (scl) begin
      fork
        frame();
        @(posedge sda iff scl);
      join_any
      disable fork;
      sda_pull = 1'b0;
      scl_pull = 1'b0;
    end
  end
endmodule

//--- verification/two_wire_serial_bus_port_tb_top.sv
// Self-checking bench for the two-wire serial bus port
module two_wire_serial_bus_port_tb_top;
  import i2c_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, pad_clk = 1'b0, arst_n = 1'b0;
  logic port_enable_bit, fast_mode, cmd_valid, cmd_ready, rx_valid;
  logic rx_ready, rx_is_addr, addr_match_irq, arb_lost, nack_seen;
  logic bus_busy, stretch, m_scl, m_sda;
  logic [7:0] own_address_register, cmd_data, rx_data, last_wr;
  logic [1:0] cmd_kind;
  logic       serial_clock_line_oe_n, serial_data_line_oe_n;
  logic       bb_scl = 1'b0, bb_sda = 1'b0;
  int         fails = 0, checked = 0, n_irq = 0, n_nack = 0, cyc = 0;
  // Pull-ups: a line is low only while some party pulls it
  wire scl = (serial_clock_line_oe_n === 1'b0 || m_scl === 1'b1 ||
              bb_scl) ? 1'b0 : 1'b1;
  wire sda = (serial_data_line_oe_n === 1'b0 || m_sda === 1'b1 ||
              bb_sda) ? 1'b0 : 1'b1;

  always #50 clk = !clk;
  initial begin
    #3.3;
    forever #6 pad_clk = !pad_clk;
  end

  two_wire_serial_bus_port two_wire_serial_bus_port_i (.clk, .arst_n,
    .pad_clk, .port_enable_bit, .fast_mode, .own_address_register,
    .cmd_valid, .cmd_ready, .cmd_kind, .cmd_data, .rx_valid, .rx_ready,
    .rx_is_addr, .rx_data, .addr_match_irq, .arb_lost, .nack_seen,
    .bus_busy, .serial_clock_line_i (scl), .serial_clock_line_o (),
    .serial_clock_line_oe_n, .serial_data_line_i (sda),
    .serial_data_line_o (), .serial_data_line_oe_n);
  bus_slave_model bus_slave_model_i (.scl, .sda, .stretch,
    .scl_pull (m_scl), .sda_pull (m_sda), .last_wr);

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d failed %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    n_irq  <= n_irq + int'(addr_match_irq === 1'b1);
    n_nack <= n_nack + int'(nack_seen === 1'b1);
    cyc    <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("CHECK FAILED t=%0t timeout", $time);
      report_and_stop();
    end
  end

  // ==========================================================
  // Drivers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Far master bit: data moves only while the clock is low
  task automatic bb_bit(input logic b, output logic s);
    bb_scl <= 1'b1;
    tick(6);
    bb_sda <= !b;
    tick(7);
    bb_scl <= 1'b0;
    for (int k = 0; k < 3000 && scl !== 1'b1; k++) @(posedge clk);
    tick(6);
    s = sda;
    tick(7);
  endtask

  task automatic bb_addr(input logic [7:0] a, output logic ack);
    logic s;
    bb_sda <= 1'b1;
    tick(13);
    for (int i = 7; i >= 0; i--) bb_bit(a[i], s);
    bb_bit(1'b1, s);
    ack = !s;
    bb_bit(1'b0, s);
    bb_sda <= 1'b0;
    tick(30);
  endtask

  task automatic push(input logic [1:0] k, input logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_data  <= d;
    do @(posedge clk); while (cmd_ready !== 1'b1);
  endtask

  task automatic mx(input logic [7:0] a, input logic [1:0] k,
                    input logic [7:0] d);
    push(CMD_START, a);
    if (k != CMD_STOP) push(k, d);
    push(CMD_STOP, 8'h00);
    cmd_valid <= 1'b0;
    while (bus_busy !== 1'b1) @(posedge clk);
    while (bus_busy !== 1'b0) @(posedge clk);
    tick(20);
  endtask

  task automatic pop(input logic [8:0] exp);
    tick(1);
    while (rx_valid !== 1'b1) @(posedge clk);
    chk({rx_is_addr, rx_data}, exp, "rx word");
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    logic ack;
    int n0;
    // Rows: expected ack, general call enable, address byte
    logic [9:0] rows [6];
    rows = '{10'h254, 10'h300, 10'h000, 10'h122, 10'h156, 10'h355};
    port_enable_bit = 1'b1;
    fast_mode = 1'b1;
    own_address_register = 8'h55;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_data = 8'h00;
    rx_ready = 1'b0;
    stretch = 1'b0;
    tick(16);
    chk({4'h0, bus_busy, cmd_ready, rx_valid, serial_data_line_oe_n,
         serial_clock_line_oe_n}, 9'h003, "reset");
    arst_n <= 1'b1;
    while (cmd_ready !== 1'b1) @(posedge clk);
    $display("test reset done");
    foreach (rows[r]) begin
      own_address_register <= {7'h2a, rows[r][8]};
      n0 = n_irq;
      tick(2);
      // Read address: queue the byte the port must send as slave
      if (rows[r][0]) push(CMD_WRITE, 8'hff);
      cmd_valid <= 1'b0;
      bb_addr(rows[r][7:0], ack);
      chk(9'(ack), 9'(rows[r][9]), "slave ack");
      chk(9'(n_irq - n0), 9'(rows[r][9]), "match irq");
      if (rows[r][9]) pop({1'b1, rows[r][7:0]});
      $display("test row %0d done", r);
    end
    stretch <= 1'b1;
    mx(8'ha0, CMD_WRITE, 8'h3c);
    chk({1'b0, last_wr}, 9'h03c, "write stretched");
    $display("test stretched write done");
    stretch <= 1'b0;
    fast_mode <= 1'b0;
    mx(8'ha0, CMD_WRITE, 8'hc3);
    chk({1'b0, last_wr}, 9'h0c3, "write standard");
    $display("test standard write done");
    fast_mode <= 1'b1;
    n0 = n_nack;
    mx(8'ha2, CMD_STOP, 8'h00);
    chk(9'(n_nack - n0), 9'h001, "address nack");
    $display("test nack done");
    mx(8'ha1, CMD_READ, 8'h01);
    pop(9'h0a5);
    $display("test read done");
    // Far master holds data low while the port sends a one
    push(CMD_START, 8'ha0);
    cmd_valid <= 1'b0;
    while (bus_busy !== 1'b1) @(posedge clk);
    bb_sda <= 1'b1;
    for (int k = 0; k < 200 && arb_lost !== 1'b1; k++) @(posedge clk);
    chk(9'(arb_lost), 9'h001, "arbitration lost");
    bb_sda <= 1'b0;
    while (bus_busy !== 1'b0) @(posedge clk);
    $display("test arbitration done");
    report_and_stop();
  end
endmodule

bind two_wire_serial_bus_port two_wire_serial_bus_port_properties
  two_wire_serial_bus_port_properties_i (.clk, .arst_n, .pad_clk,
  .rx_valid, .rx_ready, .rx_data, .addr_match_irq, .nack_seen, .bus_busy,
  .serial_clock_line_i, .serial_clock_line_o, .serial_clock_line_oe_n,
  .serial_data_line_i, .serial_data_line_o);
